// >>> hdl/lsau_pkg.sv
// constants, field layouts and state codes of the load/store address unit
// assumes one 20 MHz clock and a byte-wide core store with a request/acknowledge handshake
// Function
// RULE1: load pushes stack: memory to main, main to second, second to third
// RULE2: store writes main to memory, then second to main, third to second, main to third
// RULE3: two leading bits of the six-bit address field pick the address mode
// RULE4: workspace mode addresses first 16 words of code page by low nibble
// RULE5: double mode extends low nibble with next byte into a 12-bit address
// RULE6: double load/store advances code offset once more past the extension byte
// RULE7: double load/store puts data bank upper nibble above the 12-bit address
// RULE8: double jump pointer is code bank upper nibble over 12-bit target
// RULE9: indexed mode addresses word j past data word index in data page
// RULE10: table mode reads entry j of block zero, adds lookup offset
// RULE11: offset additions wrap within their 256-word page, never carry to banks
// RULE12: memory is 16-word blocks, 256-word pages, 4096-word chapters, 16-bit addresses
// RULE13: block zero of the data page holds the indirect address table
// RULE14: instructions split into a 4-bit type field and 4-bit operand field
// RULE15: mode 00 is workspace, mode 01 is double length
package lsau_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;

  // instruction fields
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int OPND_MSB = 3;
  localparam int OPND_LSB = 0;

  // type field = {operation, mode}
  localparam logic [1:0] OP_LOAD  = 2'h2;
  localparam logic [1:0] OP_STORE = 2'h3;
  localparam logic [3:0] TYPE_JUMP_DOUBLE = 4'h1;

  localparam logic [1:0] MODE_WORKSPACE = 2'h0;
  localparam logic [1:0] MODE_DOUBLE    = 2'h1;
  localparam logic [1:0] MODE_INDEXED   = 2'h2;
  localparam logic [1:0] MODE_TABLE     = 2'h3;

  // block number used by workspace and the indirect table
  localparam logic [3:0] BLOCK_ZERO = 4'h0;
  // chapter bits of a bank register
  localparam int CHAP_MSB = 7;
  localparam int CHAP_LSB = 4;
  localparam logic [7:0] OFFSET_STEP = 8'h01;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // register write port selectors
  localparam logic [2:0] SEL_MAIN   = 3'h0;
  localparam logic [2:0] SEL_SECOND = 3'h1;
  localparam logic [2:0] SEL_THIRD  = 3'h2;
  localparam logic [2:0] SEL_COFS   = 3'h3;
  localparam logic [2:0] SEL_CBANK  = 3'h4;
  localparam logic [2:0] SEL_LOOKUP = 3'h5;
  localparam logic [2:0] SEL_INDEX  = 3'h6;
  localparam logic [2:0] SEL_DBANK  = 3'h7;

  typedef enum logic [1:0] {
    LSAU_IDLE = 2'b00,
    LSAU_EXT  = 2'b01,
    LSAU_TBL  = 2'b10,
    LSAU_MEM  = 2'b11
  } lsau_state_e;

endpackage

// >>> hdl/lsau_addr.sv
// address former: combinational page and chapter arithmetic
// assumes register values and fetched bytes are stable while it is read
`timescale 1ns/1ps
module lsau_addr (
  input  wire logic [1:0]  mode,
  input  wire logic [3:0]  opnd,
  input  wire logic [7:0]  ext,
  input  wire logic [7:0]  entry,
  input  wire logic [7:0]  cbank,
  input  wire logic [7:0]  dbank,
  input  wire logic [7:0]  lookup,
  input  wire logic [7:0]  index,
  output logic      [15:0] eff_addr,
  output logic      [15:0] tbl_addr,
  output logic      [15:0] jump_ptr
);

  // offset arithmetic kept to 8 bits so a page wraps on itself
  function automatic logic [7:0] lsau_page_add(input logic [7:0] a, input logic [7:0] b);
    lsau_page_add = 8'(a + b); // [RULE11]
  endfunction

  always_comb begin
    // entry j of block zero in the data page
    tbl_addr = {dbank, lsau_pkg::BLOCK_ZERO, opnd}; // [RULE13] [RULE10]
    jump_ptr = {cbank[lsau_pkg::CHAP_MSB:lsau_pkg::CHAP_LSB], opnd, ext}; // [RULE8]
    eff_addr = {cbank, lsau_pkg::BLOCK_ZERO, opnd}; // [RULE4] [RULE12]
    if (mode == lsau_pkg::MODE_DOUBLE) begin
      eff_addr = {dbank[lsau_pkg::CHAP_MSB:lsau_pkg::CHAP_LSB],
                  opnd, ext}; // [RULE5] [RULE7] [RULE15]
    end else if (mode == lsau_pkg::MODE_INDEXED) begin
      eff_addr = {dbank, lsau_page_add(index, {4'h0, opnd})}; // [RULE9]
    end else if (mode == lsau_pkg::MODE_TABLE) begin
      eff_addr = {dbank, lsau_page_add(entry, lookup)}; // [RULE10]
    end
  end

endmodule // lsau_addr

// >>> hdl/lsau_top.sv
// load/store execution unit with operand stack and pointer registers
// assumes a byte core store that answers each request with a one-cycle ack
`timescale 1ns/1ps
module lsau_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr,
  input  wire logic        reg_wr,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             busy,
  output logic             done,
  output logic             bad_instr,
  output logic      [7:0]  main_opnd,
  output logic      [7:0]  second_opnd,
  output logic      [7:0]  third_opnd,
  output logic      [7:0]  code_offset,
  output logic      [7:0]  code_bank,
  output logic      [7:0]  lookup_offset,
  output logic      [7:0]  word_index,
  output logic      [7:0]  data_bank
);

  typedef struct packed {
    lsau_pkg::lsau_state_e state;
    logic [7:0]            ir;
    logic [7:0]            ext;
    logic [7:0]            x;
    logic [7:0]            y;
    logic [7:0]            z;
    logic [7:0]            p;
    logic [7:0]            q;
    logic [7:0]            e;
    logic [7:0]            f;
    logic [7:0]            g;
    logic                  req;
    logic                  we;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic                  busy;
    logic                  done;
    logic                  bad;
  } lsau_regs_s;

  localparam lsau_regs_s REGS_RESET = '{
    state: lsau_pkg::LSAU_IDLE,
    ir:    lsau_pkg::REG_RESET,
    ext:   lsau_pkg::REG_RESET,
    x:     lsau_pkg::REG_RESET,
    y:     lsau_pkg::REG_RESET,
    z:     lsau_pkg::REG_RESET,
    p:     lsau_pkg::REG_RESET,
    q:     lsau_pkg::REG_RESET,
    e:     lsau_pkg::REG_RESET,
    f:     lsau_pkg::REG_RESET,
    g:     lsau_pkg::REG_RESET,
    req:   1'b0,
    we:    1'b0,
    addr:  16'h0000,
    wdata: lsau_pkg::REG_RESET,
    busy:  1'b0,
    done:  1'b0,
    bad:   1'b0
  };

  lsau_regs_s r_reg;
  lsau_regs_s r_next;

  // instruction field helpers
  function automatic logic [3:0] lsau_type(input logic [7:0] ins);
    lsau_type = ins[lsau_pkg::TYPE_MSB:lsau_pkg::TYPE_LSB]; // [RULE14]
  endfunction

  function automatic logic [3:0] lsau_opnd(input logic [7:0] ins);
    lsau_opnd = ins[lsau_pkg::OPND_MSB:lsau_pkg::OPND_LSB]; // [RULE14]
  endfunction

  // mode and operation halves of the type field
  function automatic logic [1:0] lsau_mode(input logic [7:0] ins);
    logic [3:0] typ;
    typ       = lsau_type(ins);
    lsau_mode = typ[1:0]; // [RULE3]
  endfunction

  function automatic logic [1:0] lsau_op(input logic [7:0] ins);
    logic [3:0] typ;
    typ     = lsau_type(ins);
    lsau_op = typ[3:2];
  endfunction

  function automatic logic lsau_is_store(input logic [7:0] ins);
    lsau_is_store = (lsau_op(ins) == lsau_pkg::OP_STORE);
  endfunction

  function automatic logic lsau_is_ls(input logic [7:0] ins);
    lsau_is_ls = (lsau_op(ins) == lsau_pkg::OP_LOAD) ||
                 (lsau_op(ins) == lsau_pkg::OP_STORE);
  endfunction

  function automatic logic lsau_is_jump(input logic [7:0] ins);
    lsau_is_jump = (lsau_type(ins) == lsau_pkg::TYPE_JUMP_DOUBLE); // [RULE8]
  endfunction

  // double load/store and double jump both carry an extension byte
  function automatic logic lsau_needs_ext(input logic [7:0] ins);
    lsau_needs_ext = lsau_is_jump(ins) ||
                     (lsau_is_ls(ins) && lsau_mode(ins) == lsau_pkg::MODE_DOUBLE); // [RULE5]
  endfunction

  function automatic logic lsau_is_table(input logic [7:0] ins);
    lsau_is_table = lsau_is_ls(ins) && (lsau_mode(ins) == lsau_pkg::MODE_TABLE); // [RULE10]
  endfunction

  // stack or pointer register written from the register port
  function automatic lsau_regs_s lsau_reg_write(input lsau_regs_s cur,
                                                input logic [2:0] sel,
                                                input logic [7:0] data);
    lsau_regs_s nxt;
    nxt = cur;
    if (sel == lsau_pkg::SEL_MAIN) begin
      nxt.x = data;
    end else if (sel == lsau_pkg::SEL_SECOND) begin
      nxt.y = data;
    end else if (sel == lsau_pkg::SEL_THIRD) begin
      nxt.z = data;
    end else if (sel == lsau_pkg::SEL_COFS) begin
      nxt.p = data;
    end else if (sel == lsau_pkg::SEL_CBANK) begin
      nxt.q = data;
    end else if (sel == lsau_pkg::SEL_LOOKUP) begin
      nxt.e = data;
    end else if (sel == lsau_pkg::SEL_INDEX) begin
      nxt.f = data;
    end else begin
      nxt.g = data;
    end
    return nxt;
  endfunction

  // decode source: the new instruction while idle, the held one afterwards
  logic [7:0]  cur_ir;
  logic [7:0]  cur_ext;
  logic [15:0] eff_addr;
  logic [15:0] tbl_addr;
  logic [15:0] jump_ptr;
  logic [1:0]  cur_mode;
  logic [3:0]  cur_opnd;
  logic        held_is_jump;
  logic        held_is_store;

  always_comb begin
    cur_ir = r_reg.ir;
    if (r_reg.state == lsau_pkg::LSAU_IDLE) begin
      cur_ir = instr;
    end
    cur_ext = r_reg.ext;
    if (r_reg.state == lsau_pkg::LSAU_EXT) begin
      cur_ext = mem_rdata;
    end
    cur_mode = lsau_mode(cur_ir);
    cur_opnd = lsau_opnd(cur_ir);
  end

  // decode of the instruction held while its transfers run
  always_comb begin
    held_is_jump  = lsau_is_jump(r_reg.ir);
    held_is_store = lsau_is_store(r_reg.ir);
  end

  lsau_addr u_addr (
    .mode     (cur_mode),
    .opnd     (cur_opnd),
    .ext      (cur_ext),
    .entry    (mem_rdata),
    .cbank    (r_reg.q),
    .dbank    (r_reg.g),
    .lookup   (r_reg.e),
    .index    (r_reg.f),
    .eff_addr (eff_addr),
    .tbl_addr (tbl_addr),
    .jump_ptr (jump_ptr)
  );

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    case (r_reg.state)
      lsau_pkg::LSAU_IDLE: begin
        if (instr_valid) begin
          r_next.ir   = instr;
          r_next.busy = 1'b1;
          r_next.bad  = 1'b0;
          r_next.we   = 1'b0;
          if (lsau_needs_ext(instr)) begin
            // fetch the extension byte the code offset points at
            r_next.state = lsau_pkg::LSAU_EXT;
            r_next.req   = 1'b1;
            r_next.addr  = {r_reg.q, r_reg.p};
          end else if (lsau_is_table(instr)) begin
            r_next.state = lsau_pkg::LSAU_TBL;
            r_next.req   = 1'b1;
            r_next.addr  = tbl_addr; // [RULE10] [RULE13]
          end else if (lsau_is_ls(instr)) begin
            r_next.state = lsau_pkg::LSAU_MEM;
            r_next.req   = 1'b1;
            r_next.addr  = eff_addr; // [RULE4] [RULE9]
            r_next.we    = lsau_is_store(instr);
            r_next.wdata = r_reg.x; // [RULE2]
          end else begin
            // not a load, store or double jump: refuse and finish at once
            r_next.bad  = 1'b1;
            r_next.done = 1'b1;
            r_next.busy = 1'b0;
          end
        end else if (reg_wr) begin
          // built on r_next so the done pulse still drops
          r_next = lsau_reg_write(r_next, reg_sel, reg_wdata);
        end
      end
      lsau_pkg::LSAU_EXT: begin
        if (mem_ack) begin
          r_next.ext = mem_rdata;
          if (held_is_jump) begin
            // new code bank keeps its chapter, takes the target page
            r_next.q     = jump_ptr[15:8]; // [RULE8]
            r_next.p     = jump_ptr[7:0]; // [RULE8]
            r_next.req   = 1'b0;
            r_next.state = lsau_pkg::LSAU_IDLE;
            r_next.busy  = 1'b0;
            r_next.done  = 1'b1;
          end else begin
            // step past the extension byte inside the code page
            r_next.p     = 8'(r_reg.p + lsau_pkg::OFFSET_STEP); // [RULE6] [RULE11]
            r_next.state = lsau_pkg::LSAU_MEM;
            r_next.addr  = eff_addr; // [RULE5] [RULE7]
            r_next.we    = held_is_store;
            r_next.wdata = r_reg.x;
          end
        end
      end
      lsau_pkg::LSAU_TBL: begin
        if (mem_ack) begin
          r_next.state = lsau_pkg::LSAU_MEM;
          r_next.addr  = eff_addr; // [RULE10]
          r_next.we    = held_is_store;
          r_next.wdata = r_reg.x;
        end
      end
      lsau_pkg::LSAU_MEM: begin
        if (mem_ack) begin
          if (r_reg.we) begin
            r_next.x = r_reg.y; // [RULE2]
            r_next.y = r_reg.z; // [RULE2]
            r_next.z = r_reg.x; // [RULE2]
          end else begin
            r_next.x = mem_rdata; // [RULE1]
            r_next.y = r_reg.x; // [RULE1]
            r_next.z = r_reg.y; // [RULE1]
          end
          r_next.req   = 1'b0;
          r_next.we    = 1'b0;
          r_next.state = lsau_pkg::LSAU_IDLE;
          r_next.busy  = 1'b0;
          r_next.done  = 1'b1;
        end
      end
      default: begin
        r_next = REGS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_req       = r_reg.req;
  assign mem_we        = r_reg.we;
  assign mem_addr      = r_reg.addr;
  assign mem_wdata     = r_reg.wdata;
  assign busy          = r_reg.busy;
  assign done          = r_reg.done;
  assign bad_instr     = r_reg.bad;
  assign main_opnd     = r_reg.x;
  assign second_opnd   = r_reg.y;
  assign third_opnd    = r_reg.z;
  assign code_offset   = r_reg.p;
  assign code_bank     = r_reg.q;
  assign lookup_offset = r_reg.e;
  assign word_index    = r_reg.f;
  assign data_bank     = r_reg.g;

endmodule // lsau_top

// >>> dv/lsau_asserts.sv
// checker for the load/store unit: stack moves and address forming
// assumes it is bound into lsau_top and sees only its ports
`timescale 1ns/1ps
module lsau_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [7:0]  instr,
  input wire logic        mem_ack,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        bad_instr,
  input wire logic [7:0]  main_opnd,
  input wire logic [7:0]  second_opnd,
  input wire logic [7:0]  third_opnd,
  input wire logic [7:0]  code_offset,
  input wire logic [7:0]  code_bank,
  input wire logic [7:0]  lookup_offset,
  input wire logic [7:0]  word_index,
  input wire logic [7:0]  data_bank
);
  logic [7:0] ir, rd, m0, s0, t0, c0, b0;
  logic [1:0] acks;
  wire        take = instr_valid && !busy;
  wire        fin  = done && !bad_instr;
  wire        rq   = mem_req && ir[7];

  // snapshot at take, last read byte and access count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {ir, rd, m0, s0, t0, c0, b0, acks} <= '0;
    end else begin
      if (take) begin
        {ir, m0, s0, t0} <= {instr, main_opnd, second_opnd, third_opnd};
        {c0, b0, acks} <= {code_offset, code_bank, 2'h0};
      end
      if (mem_ack) begin
        rd <= mem_rdata;
        acks <= acks + 2'h1;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LOAD_PUSH: assert property (fin && ir[7:6] == 2'h2 |->
    main_opnd == rd && second_opnd == m0 && third_opnd == s0) else $error("load push");
  AST_STORE_POP: assert property (fin && ir[7:6] == 2'h3 |->
    main_opnd == s0 && second_opnd == t0 && third_opnd == m0) else $error("store pop");
  AST_STORE_DATA: assert property (mem_req && mem_we |->
    mem_wdata == m0 && ir[7:6] == 2'h3) else $error("store data");
  AST_WS_ADDR: assert property (rq && ir[5:4] == 2'h0 |->
    mem_addr == {code_bank, 4'h0, ir[3:0]}) else $error("workspace addr");
  AST_DBL_ADDR: assert property (rq && ir[5:4] == 2'h1 |-> mem_addr ==
    (acks == 2'h0 ? {code_bank, code_offset} : {data_bank[7:4], ir[3:0], rd}))
    else $error("double addr");
  AST_IDX_ADDR: assert property (rq && ir[5:4] == 2'h2 |->
    mem_addr == {data_bank, word_index + {4'h0, ir[3:0]}}) else $error("indexed addr");
  AST_TBL_ADDR: assert property (rq && ir[5:4] == 2'h3 |-> mem_addr ==
    (acks == 2'h0 ? {data_bank, 4'h0, ir[3:0]} : {data_bank, rd + lookup_offset}))
    else $error("table addr");
  AST_DBL_SKIP: assert property (fin && ir[7] && ir[5:4] == 2'h1 |->
    code_offset == c0 + 8'h01 && code_bank == b0) else $error("double skip");
  AST_JUMP: assert property (done && ir[7:4] == 4'h1 |->
    code_bank == {b0[7:4], ir[3:0]} && code_offset == rd) else $error("double jump");
  AST_BAD: assert property (take && !instr[7] && instr[7:4] != 4'h1 |=>
    done && bad_instr) else $error("refused type");

  cover property (fin && ir[7:6] == 2'h2);
  cover property (fin && ir[7:6] == 2'h3);
  cover property (done && bad_instr);
  cover property (fin && ir[7] && ir[5:4] == 2'h1);
  cover property (fin && ir[7] && ir[5:4] == 2'h3);
endmodule // lsau_asserts

bind lsau_top lsau_asserts u_lsau_asserts (
  .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .busy(busy), .done(done), .bad_instr(bad_instr),
  .main_opnd(main_opnd), .second_opnd(second_opnd), .third_opnd(third_opnd),
  .code_offset(code_offset), .code_bank(code_bank), .lookup_offset(lookup_offset),
  .word_index(word_index), .data_bank(data_bank));

// >>> dv/lsau_mem_model.sv
// core store model: byte array, answers each request with a one-cycle ack
// assumes the bench preloads mem and sets the answer delay
`timescale 1ns/1ps
module lsau_mem_model (
  input wire logic        clk,
  input wire logic [1:0]  delay,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  output logic            mem_ack,
  output logic [7:0]      mem_rdata
);
  logic [7:0] mem [0:65535];
  int         wait_cnt = 0;

  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;

  // read data toggles when not answering, so stale bytes never look valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= delay) begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr] <= mem_wdata;
        else mem_rdata <= mem[mem_addr];
      end
    end
  end
endmodule // lsau_mem_model

// >>> dv/lsau_top_test.sv
// self-checking bench: random registers and store, all eight load/store types, double jump and two refused types
// assumes lsau_top, lsau_mem_model and the bound checker are compiled
`timescale 1ns/1ps
module lsau_top_test;
  logic        clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0;
  logic [7:0]  instr = 8'h00, reg_wdata = 8'h00, sd = 8'h2D;
  logic [2:0]  reg_sel = 3'h0;
  logic [1:0]  delay = 2'h0;
  logic        mem_ack, mem_req, mem_we, busy, done, bad_instr;
  logic [7:0]  mem_rdata, mem_wdata;
  logic [15:0] mem_addr;
  logic [7:0]  v [8];
  logic [7:0]  r [8];
  logic [7:0]  rm [0:65535];
  int          error_cnt = 0, samples_checked = 0;
  logic [3:0]  types [11] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h1, 4'h0, 4'h5};

  always #25 clk = ~clk;

  lsau_top u_lsau_top (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .busy(busy), .done(done), .bad_instr(bad_instr),
    .main_opnd(v[0]), .second_opnd(v[1]), .third_opnd(v[2]), .code_offset(v[3]),
    .code_bank(v[4]), .lookup_offset(v[5]), .word_index(v[6]), .data_bank(v[7]));

  lsau_mem_model u_lsau_mem_model (.clk(clk), .delay(delay), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  function automatic logic [7:0] rnd();
    sd = {sd[6:0], sd[7] ^ sd[5] ^ sd[4] ^ sd[3]};
    return sd;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // all-ones pass puts every offset at the page edge
  task automatic load_regs(input bit ones);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      r[s] = ones ? 8'hFF : rnd();
      reg_wr <= 1'b1;
      reg_sel <= s[2:0];
      reg_wdata <= r[s];
    end
    @(posedge clk);
    reg_wr <= 1'b0;
    delay <= 2'(rnd() % 8'h03);
  endtask

  task automatic run(input logic [7:0] i);
    logic [15:0] a;
    logic [7:0]  t;
    case (i[5:4])
      2'h0: a = {r[4], 4'h0, i[3:0]};
      2'h1: a = {r[7][7:4], i[3:0], rm[{r[4], r[3]}]};
      2'h2: a = {r[7], r[6] + {4'h0, i[3:0]}};
      default: a = {r[7], rm[{r[7], 4'h0, i[3:0]}] + r[5]};
    endcase
    if (i[7:4] == 4'h1) begin
      t = rm[{r[4], r[3]}];
      r[4] = {r[4][7:4], i[3:0]};
      r[3] = t;
    end else if (i[7]) begin
      if (i[5:4] == 2'h1) r[3] = r[3] + 8'h01;
      if (!i[6]) {r[2], r[1], r[0]} = {r[1], r[0], rm[a]};
      else rm[a] = r[0];
      if (i[6]) {r[0], r[1], r[2]} = {r[1], r[2], r[0]};
    end
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= i;
    @(posedge clk);
    instr_valid <= 1'b0;
    for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
    chk("done", done, 16'h0001);
    chk("busy", busy, 16'h0000);
    chk("bad_instr", bad_instr, {15'h0000, !i[7] && i[7:4] != 4'h1});
    foreach (v[k]) chk($sformatf("reg %0d", k), v[k], r[k]);
    chk("store word", u_lsau_mem_model.mem[a], rm[a]);
  endtask

  initial begin
    for (int k = 0; k < 65536; k++) rm[k] = rnd();
    u_lsau_mem_model.mem = rm;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (types[n]) begin
      for (int p = 0; p < 6; p++) begin
        load_regs(p == 0);
        run({types[n], 4'(rnd())});
      end
      $display("test type %h done", types[n]);
    end
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule // lsau_top_test
